// file: rtl/acsp_pkg.sv
// constants for the converter serial register port
package acsp_pkg;
	// word length and bit counter
	localparam int          CNT_W      = 5;
	localparam logic [4:0]  WORD_BITS  = 5'h10;
	localparam logic [4:0]  LAST_BIT   = 5'h0f;

	// reset values
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] SETUP_RST  = 16'h058b;

	// setup word field positions
	localparam int          SS_BIT     = 15;
	localparam int          MUX_MSB    = 14;
	localparam int          MUX_LSB    = 12;
	localparam int          PGA_MSB    = 11;
	localparam int          PGA_LSB    = 9;
	localparam int          MODE_BIT   = 8;
	localparam int          DR_MSB     = 7;
	localparam int          DR_LSB     = 5;
	localparam int          TS_BIT     = 4;
	localparam int          PULL_BIT   = 3;
	localparam int          KEY_MSB    = 2;
	localparam int          KEY_LSB    = 1;
	localparam int          RSV_BIT    = 0;

	// write key value that allows an update
	localparam logic [1:0]  KEY_VALID  = 2'h1;

	// input selector encodings
	localparam logic [1:0]  IN_0       = 2'h0;
	localparam logic [1:0]  IN_1       = 2'h1;
	localparam logic [1:0]  IN_2       = 2'h2;
	localparam logic [1:0]  IN_3       = 2'h3;
endpackage

// file: rtl/acsp_pin_if.sv
// synchronised pin events passed from the sampler to the port logic
`timescale 1ns/1ns
interface acsp_pin_if;
	logic cs_act;
	logic sclk_rise;
	logic sclk_fall;
	logic din_s;

	modport src
	(
		output cs_act,
		output sclk_rise,
		output sclk_fall,
		output din_s
	);
	modport dst
	(
		input  cs_act,
		input  sclk_rise,
		input  sclk_fall,
		input  din_s
	);
endinterface

// file: rtl/acsp_pin_sync.sv
// two-stage synchronisers and serial clock edge finder
`timescale 1ns/1ns
module acsp_pin_sync
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// raw pins
	input  wire logic  cs_n,
	input  wire logic  sclk,
	input  wire logic  din,
	// synchronised events
	acsp_pin_if.src    pin
);
	import acsp_pkg::*;

	typedef struct packed
	{
		logic cs1;
		logic cs2;
		logic sc1;
		logic sc2;
		logic sc3;
		logic d1;
		logic d2;
	} acsp_sync_st_t;

	acsp_sync_st_t s_q;
	acsp_sync_st_t s_d;

	always_comb
	begin
		s_d     = s_q;
		s_d.cs1 = cs_n;
		s_d.cs2 = s_q.cs1;
		s_d.sc1 = sclk;
		s_d.sc2 = s_q.sc1;
		s_d.sc3 = s_q.sc2;
		s_d.d1  = din;
		s_d.d2  = s_q.d1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= 7'h63;
		else
			s_q <= s_d;
	end

	// edges come from the second and third stages only
	assign pin.cs_act    = ~s_q.cs2;
	assign pin.sclk_rise = s_q.sc2 & ~s_q.sc3;
	assign pin.sclk_fall = ~s_q.sc2 & s_q.sc3;
	assign pin.din_s     = s_q.d2;
endmodule

// file: rtl/acsp_port.sv
// serial register port of a 16-bit sensor converter
// Operation
// R1 - a 16-clock transaction carries only the conversion result out
// R2 - host raises chip select after the sixteenth clock to reset the port
// R3 - after chip select falls, result shifts out from the first rising edge
// R4 - ready low at readout means new result; high means the previous one
// R5 - exactly two registers: conversion result and setup word
// R6 - result is read-only 16-bit two's complement, reset zero
// R7 - result stays zero after reset until the first conversion ends
// R8 - setup word resets to 058b
// R9 - bit 15 starts one conversion when powered down; always reads 0
// R10 - bits 14:12 pick the input pair, reset 000
// R11 - bits 11:9 pick the full-scale span, default 010
// R12 - bit 8: 0 continuous, 1 power-down single-shot (default)
// R13 - bits 7:5 pick the data rate, 8 to 860 per second
// R14 - bit 4 selects the temperature sensor instead of the inputs
// R15 - bit 3 enables the weak pullup only while chip select is high
// R16 - setup updates only when received bits 2:1 equal 01
// R17 - bit 0 is written as 1 and may read either value
// R18 - serial input sampled on each falling serial clock edge
// R19 - output bits launched on rising edges, most significant first
// R20 - chip select high resets the port, ignores clock, floats output
// R21 - selected and idle, the output low means a new result is ready
// R22 - a setup word takes effect only after all 16 bits arrive
// R23 - result is captured at transaction start and held until it ends
`timescale 1ns/1ns
module acsp_port
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// serial pins
	input  wire logic                   cs_n,
	input  wire logic                   sclk,
	input  wire logic                   din,
	output logic                        serial_out_ready_n,
	output logic                        serial_out_ready_oe_n,
	output logic                        pullup_on,
	// converter core
	input  wire logic [15:0]            result_data,
	input  wire logic                   result_valid,
	input  wire logic                   conv_busy,
	output logic                        start_conv,
	// decoded setup and ready status
	output logic [1:0]                  input_pos,
	output logic [1:0]                  input_neg,
	output logic                        neg_is_ground,
	output logic [12:0]                 full_scale_span_mv,
	output logic                        continuous_mode,
	output logic [9:0]                  sample_rate_sps,
	output logic                        thermo_select,
	output logic [15:0]                 setup_value,
	output logic                        data_ready
);
	import acsp_pkg::*;

	typedef struct packed
	{
		logic [15:0]      result;
		logic             ready;
		logic [15:0]      setup;
		logic [15:0]      sh_out;
		logic [15:0]      sh_in;
		logic [CNT_W-1:0] cnt;
		logic             active;
		logic             drive;
		logic             out;
		logic             start;
	} acsp_port_st_t;

	acsp_port_st_t s_q;
	acsp_port_st_t s_d;
	logic [15:0]   word_in;

	acsp_pin_if pin ();

	acsp_pin_sync u_sync
	(
		.clk  (clk),
		.rst  (rst),
		.cs_n (cs_n),
		.sclk (sclk),
		.din  (din),
		.pin  (pin)
	);

	// word as it stands after the current falling edge
	assign word_in = {s_q.sh_in[14:0], pin.din_s}; // R18

	always_comb
	begin
		s_d       = s_q;
		s_d.start = 1'b0;
		s_d.drive = pin.cs_act;
		if (result_valid)
			s_d.result = result_data; // R6 R7
		if (!pin.cs_act)
		begin
			// interface held in reset, clock ignored
			s_d.active = 1'b0; // R20 R2
			s_d.cnt    = '0;
			s_d.out    = 1'b1;
		end
		else
		begin
			if (!s_q.active)
				s_d.out = ~s_q.ready; // R21 R4
			if (pin.sclk_rise)
			begin
				if (!s_q.active)
				begin
					// lock the buffered result for this transaction
					s_d.active = 1'b1; // R3 R23
					s_d.out    = s_q.result[15]; // R19
					s_d.sh_out = {s_q.result[14:0], 1'b0};
					s_d.ready  = 1'b0;
				end
				else
				begin
					s_d.out    = s_q.sh_out[15]; // R19
					s_d.sh_out = {s_q.sh_out[14:0], 1'b0};
				end
			end
			if (pin.sclk_fall && s_q.active && s_q.cnt < WORD_BITS)
			begin
				s_d.sh_in = word_in; // R18
				s_d.cnt   = s_q.cnt + 5'h01; // R1
				if (s_q.cnt == LAST_BIT
				    && word_in[KEY_MSB:KEY_LSB] == KEY_VALID) // R16 R22
				begin
					s_d.setup = {1'b0, word_in[14:1], 1'b1}; // R9 R17
					if (word_in[SS_BIT] && s_q.setup[MODE_BIT]
					    && !conv_busy)
						s_d.start = 1'b1; // R9
				end
			end
		end
		// a new result wins over the clear at readout start
		if (result_valid)
			s_d.ready = 1'b1; // R4
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q        <= '0;
			s_q.result <= RESULT_RST; // R6
			s_q.setup  <= SETUP_RST; // R8
			s_q.out    <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// pin drive
	assign serial_out_ready_n    = s_q.out;
	assign serial_out_ready_oe_n = ~s_q.drive; // R20
	assign pullup_on             = ~s_q.drive & s_q.setup[PULL_BIT]; // R15

	// register and status outputs
	assign start_conv      = s_q.start;
	assign setup_value     = s_q.setup; // R5
	assign data_ready      = s_q.ready;
	assign continuous_mode = ~s_q.setup[MODE_BIT]; // R12
	assign thermo_select   = s_q.setup[TS_BIT]; // R14

	// input pair decode
	always_comb
	begin
		input_pos     = IN_0;
		input_neg     = IN_1;
		neg_is_ground = 1'b0;
		case (s_q.setup[MUX_MSB:MUX_LSB]) // R10
			3'h0:
			begin
				input_pos = IN_0;
				input_neg = IN_1;
			end
			3'h1:
			begin
				input_pos = IN_0;
				input_neg = IN_3;
			end
			3'h2:
			begin
				input_pos = IN_1;
				input_neg = IN_3;
			end
			3'h3:
			begin
				input_pos = IN_2;
				input_neg = IN_3;
			end
			3'h4:
			begin
				input_pos     = IN_0;
				neg_is_ground = 1'b1;
			end
			3'h5:
			begin
				input_pos     = IN_1;
				neg_is_ground = 1'b1;
			end
			3'h6:
			begin
				input_pos     = IN_2;
				neg_is_ground = 1'b1;
			end
			default:
			begin
				input_pos     = IN_3;
				neg_is_ground = 1'b1;
			end
		endcase
	end

	// full-scale span in millivolts
	always_comb
	begin
		case (s_q.setup[PGA_MSB:PGA_LSB]) // R11
			3'h0:    full_scale_span_mv = 13'h1800;
			3'h1:    full_scale_span_mv = 13'h1000;
			3'h2:    full_scale_span_mv = 13'h0800;
			3'h3:    full_scale_span_mv = 13'h0400;
			3'h4:    full_scale_span_mv = 13'h0200;
			default: full_scale_span_mv = 13'h0100;
		endcase
	end

	// output data rate in samples per second
	always_comb
	begin
		case (s_q.setup[DR_MSB:DR_LSB]) // R13
			3'h0:    sample_rate_sps = 10'h008;
			3'h1:    sample_rate_sps = 10'h010;
			3'h2:    sample_rate_sps = 10'h020;
			3'h3:    sample_rate_sps = 10'h040;
			3'h4:    sample_rate_sps = 10'h080;
			3'h5:    sample_rate_sps = 10'h0fa;
			3'h6:    sample_rate_sps = 10'h1db;
			default: sample_rate_sps = 10'h35c;
		endcase
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_first_rise;
		pin.cs_act && pin.sclk_rise && !s_q.active;
	endsequence

	sequence s_last_fall;
		pin.cs_act && pin.sclk_fall && s_q.active && s_q.cnt == LAST_BIT;
	endsequence

	chk_hiz_when_free: assert property // R20
		(!pin.cs_act |=> serial_out_ready_oe_n && !s_q.active)
		else $error("output driven while deselected");

	chk_idle_ready_level: assert property // R21
		(pin.cs_act && !s_q.active && !pin.sclk_rise
		 |=> serial_out_ready_n == !$past(s_q.ready))
		else $error("idle level does not show ready");

	chk_first_bit_msb: assert property // R3
		(s_first_rise |=> serial_out_ready_n == $past(s_q.result[15])
		 && s_q.active)
		else $error("first rising edge did not launch msb");

	chk_ready_cleared: assert property // R4
		((s_first_rise and !result_valid) |=> !s_q.ready)
		else $error("ready not cleared at readout");

	chk_shift_held: assert property // R23
		(s_q.active && pin.cs_act && !pin.sclk_rise |=> $stable(s_q.sh_out))
		else $error("output shift register changed mid word");

	chk_next_bit: assert property // R19
		(s_q.active && pin.cs_act && pin.sclk_rise
		 |=> serial_out_ready_n == $past(s_q.sh_out[15]))
		else $error("wrong bit launched");

	chk_key_guard: assert property // R16
		((s_last_fall and word_in[KEY_MSB:KEY_LSB] != KEY_VALID)
		 |=> $stable(s_q.setup))
		else $error("setup written with invalid key");

	chk_key_write: assert property // R16
		((s_last_fall and word_in[KEY_MSB:KEY_LSB] == KEY_VALID)
		 |=> s_q.setup[14:1] == $past(word_in[14:1]))
		else $error("valid setup word not stored");

	chk_partial_word: assert property // R22
		(s_q.cnt != LAST_BIT |=> $stable(s_q.setup))
		else $error("setup changed before word complete");

	chk_ss_reads_zero: assert property // R9
		(!s_q.setup[SS_BIT] ##1 !s_q.setup[SS_BIT])
		else $error("start bit reads back one");

	chk_start_cause: assert property // R9
		(start_conv |-> !$past(conv_busy) && $past(s_q.setup[MODE_BIT]))
		else $error("start without power-down");

	chk_result_load: assert property // R6
		(result_valid |=> s_q.result == $past(result_data) && s_q.ready)
		else $error("result not loaded");

	chk_pullup_gate: assert property // R15
		(pullup_on |-> serial_out_ready_oe_n && s_q.setup[PULL_BIT])
		else $error("pullup while driving");

	chk_drive_when_sel: assert property // R20 R21
		(pin.cs_act |=> !serial_out_ready_oe_n && !pullup_on)
		else $error("output not driven while selected");

	chk_pullup_when_free: assert property // R15
		(!pin.cs_act && s_q.setup[PULL_BIT] |=> pullup_on)
		else $error("pullup missing while deselected");

	chk_port_reset: assert property // R2 R20
		(!pin.cs_act |=> s_q.cnt == '0)
		else $error("bit count kept while deselected");

	chk_count_bound: assert property // R1
		(s_q.cnt <= WORD_BITS)
		else $error("bit count past one word");

	chk_sample_fall: assert property // R18
		(pin.cs_act && pin.sclk_fall && s_q.active && s_q.cnt < WORD_BITS
		 |=> s_q.sh_in[0] == $past(pin.din_s))
		else $error("serial input not taken at falling edge");

	chk_no_start_busy: assert property // R9
		(conv_busy |=> !start_conv)
		else $error("start while conversion running");

	chk_start_single: assert property // R9
		(start_conv |=> !start_conv)
		else $error("start longer than one cycle");
endmodule

// file: tb/acsp_host.sv
// behavioural spi mode-1 host for the converter serial port
`timescale 1ns/1ns
module acsp_host
(
	// bench clock that paces the link
	input  wire logic  clk,
	// pins toward the port
	output logic       cs_n,
	output logic       sclk,
	output logic       din,
	// resolved data-out line
	input  wire logic  line
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end

	// released din keeps changing between frames
	always @(posedge clk)
		if (cs_n)
			din <= ~din;

	// n clocks of 64 ns, msb first; line sampled just before each rise
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] rd, output logic rdy);
		rd = 16'h0000;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		rdy = line;
		for (int i = 15; i > 15 - n; i--)
		begin
			sclk <= 1'b1;
			din  <= w[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			rd[i] = line;
		end
		repeat (3) @(posedge clk);
		cs_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the converter serial register port
`timescale 1ns/1ns
module testbench;
	import acsp_pkg::*;
	logic        clk, rst, cs_n, sclk, din, line, junk, rdy;
	logic        serial_out_ready_n, serial_out_ready_oe_n, pullup_on;
	logic        result_valid, conv_busy, start_conv, neg_is_ground;
	logic        continuous_mode, thermo_select, data_ready;
	logic [1:0]  input_pos, input_neg;
	logic [12:0] full_scale_span_mv;
	logic [9:0]  sample_rate_sps;
	logic [15:0] result_data, setup_value, setup, rd, w, d;
	int          n_errors, comparisons, seed, starts;
	logic [12:0] span_t [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400,
		13'h0200, 13'h0100, 13'h0100, 13'h0100};
	logic [9:0]  rate_t [8] = '{10'h008, 10'h010, 10'h020, 10'h040,
		10'h080, 10'h0fa, 10'h1db, 10'h35c};

	acsp_port DUT (.clk, .rst, .cs_n, .sclk, .din, .serial_out_ready_n,
		.serial_out_ready_oe_n, .pullup_on, .result_data, .result_valid,
		.conv_busy, .start_conv, .input_pos, .input_neg, .neg_is_ground,
		.full_scale_span_mv, .continuous_mode, .sample_rate_sps,
		.thermo_select, .setup_value, .data_ready);
	acsp_host host (.clk, .cs_n, .sclk, .din, .line);

	// a floating line shows a changing level unless pullup_on holds it high, never the last bit
	assign line = !serial_out_ready_oe_n ? serial_out_ready_n
		: pullup_on ? 1'b1 : junk;
	always #4 clk = ~clk;
	always @(posedge clk) junk <= ~junk;
	always @(posedge clk) if (start_conv) starts <= starts + 1;

	function automatic logic [15:0] after_write(input logic [15:0] o, v);
		if (v[KEY_MSB:KEY_LSB] != KEY_VALID)
			return o;
		return {1'b0, v[14:1], 1'b1};
	endfunction

	task automatic cmp(input string what, input logic [15:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic push(input logic [15:0] v);
		@(posedge clk);
		result_data  <= v;
		result_valid <= 1'b1;
		@(posedge clk);
		result_valid <= 1'b0;
	endtask

	task automatic frame(input logic [15:0] v, input int n);
		host.xfer(v, n, rd, rdy);
		if (n == 16)
			setup = after_write(setup, v);
		cmp("setup", setup, setup_value);
		cmp("oe_n", 16'h1, 16'(serial_out_ready_oe_n));
	endtask

	task automatic check_decode;
		logic [2:0] m;
		m = setup[14:12];
		cmp("span", 16'(span_t[setup[11:9]]), 16'(full_scale_span_mv));
		cmp("rate", 16'(rate_t[setup[7:5]]), 16'(sample_rate_sps));
		cmp("pos", 16'he490 >> {m, 1'b0} & 16'h3, 16'(input_pos));
		cmp("gnd", 16'(m[2]), 16'(neg_is_ground));
		if (!m[2])
			cmp("neg", 16'h00fd >> {m, 1'b0} & 16'h3, 16'(input_neg));
		cmp("mode", 16'(!setup[8]), 16'(continuous_mode));
		cmp("thermo", 16'(setup[4]), 16'(thermo_select));
		cmp("pull", 16'(setup[3]), 16'(pullup_on));
	endtask

	initial
	begin
		clk          = 1'b0;
		rst          = 1'b1;
		result_valid = 1'b0;
		conv_busy    = 1'b0;
		result_data  = 16'h0000;
		junk         = 1'b0;
		n_errors     = 0;
		comparisons  = 0;
		starts       = 0;
		seed         = 47;
		setup        = SETUP_RST;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		cmp("ready", 16'h0, 16'(data_ready));
		check_decode;
		frame(16'hffff, 16);
		cmp("result", RESULT_RST, rd);
		cmp("idle", 16'h1, 16'(rdy));
		$display("test reset done");
		d = 16'($random(seed));
		push(d);
		w = 16'($random(seed)) & 16'h7ffb | 16'h0003;
		frame(w, 16);
		cmp("idle", 16'h0, 16'(rdy));
		cmp("result", d, rd);
		frame(16'h0000, 16);
		cmp("idle", 16'h1, 16'(rdy));
		cmp("result", d, rd);
		fork
			frame(16'h0000, 16);
			begin
				repeat (40) @(posedge clk);
				push(~d);
			end
		join
		cmp("result", d, rd);
		cmp("ready", 16'h1, 16'(data_ready));
		$display("test readout done");
		for (int i = 0; i < 16; i++)
		begin
			w = 16'($random(seed)) & 16'h7fff | 16'h0001;
			w[14:12] = i[2:0];
			w[11:9] = i[2:0];
			w[7:5] = i[2:0];
			w[2:1] = i < 8 ? KEY_VALID : 2'($random(seed));
			frame(w, 16);
			check_decode;
		end
		cmp("starts", 16'h0, 16'(starts));
		$display("test setup fields done");
		frame(16'h058b, 16);
		frame(16'h858b, 16);
		cmp("starts", 16'h1, 16'(starts));
		@(posedge clk) conv_busy <= 1'b1;
		frame(16'h858b, 16);
		cmp("starts", 16'h1, 16'(starts));
		@(posedge clk) conv_busy <= 1'b0;
		frame(16'h048b, 16);
		frame(16'h848b, 16);
		cmp("starts", 16'h1, 16'(starts));
		$display("test single shot done");
		frame(16'h248b, 8);
		frame(16'h248b, 15);
		$display("test partial word done");
		report_and_stop;
	end

	initial
	begin
		#200000;
		n_errors++;
		report_and_stop;
	end
endmodule
